/* File: hdl/uart_core.sv */
// serial transmitter and receiver with four-deep fifos and apb registers
// assumes a single pclk domain; serial_in_line is asynchronous
`default_nettype none
module uart_core
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic transmit_irq_flag,
   output logic receive_irq_flag
);
   typedef enum logic [1:0] {tx_idle, tx_shift} tx_state_t;
   typedef enum logic [1:0] {rx_idle, rx_bits} rx_state_t;
   logic [15:0] mode_q; // mode_reg
   logic [15:0] baud_q; // baud_divisor_reg
   logic transmit_enable_q; // transmitter on
   logic transmit_irq_select_q; // tx irq mode
   logic send_break_q; // break request
   logic [1:0] receive_irq_select_q; // rx irq mode
   logic overrun_flag_q; // sticky overrun
   logic module_enable; // decoded enable
   logic [1:0] data_parity_select; // frame format
   logic wr; // apb write access
   logic rd; // apb read access
   logic tick; // oversample tick
   logic txf_push, txf_pop, txf_full; // transmit fifo handshakes
   logic [fifo_width-1:0] txf_head; // transmit fifo head
   logic [2:0] txf_count; // transmit fifo level
   logic rxf_push, rxf_pop, rxf_full; // receive fifo handshakes
   logic [fifo_width-1:0] rxf_head; // receive fifo head
   logic [2:0] rxf_count; // receive fifo level
   logic [fifo_width-1:0] rxf_wdata; // receive entry
   logic flush; // disable flush
   tx_state_t tx_state_q; // transmitter state
   logic [11:0] tx_shift_q; // transmit_shift_reg: data, parity, stops
   logic [3:0] tx_bits_q; // bits left
   logic [3:0] tx_sub_q; // oversample phase
   logic tx_line_q; // unbroken line level
   rx_state_t rx_state_q; // receiver state
   logic [9:0] receive_shift_reg_q; // gathered bits
   logic [3:0] rx_bits_q; // bits gathered
   logic [3:0] rx_sub_q; // oversample phase
   logic rx_meta_q, rx_sync_q, rx_prev_q; // input synchroniser
   logic [3:0] frame_len; // data plus parity bits

   // parity of the low eight bits
   function automatic logic par8(input logic [7:0] d);
      par8 = ^d;
   endfunction : par8

   assign module_enable = mode_q[module_enable_bit];
   assign data_parity_select = mode_q[data_parity_select_lsb +: 2];
   assign flush = !module_enable;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign frame_len = (data_parity_select == fmt_8n) ? 4'h8 : 4'h9;

   // apb always answers in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end
   assign pslverr = 1'b0;

   // configuration registers; mode and divisor survive disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= mode_reset;
         baud_q <= baud_reset;
         transmit_irq_select_q <= 1'b0;
         receive_irq_select_q <= 2'h0;
      end else if (wr && pready) begin
         if (paddr == mode_reg_off) mode_q <= pwdata[15:0];
         if (paddr == baud_divisor_reg_off) baud_q <= pwdata[15:0];
         if (paddr == status_control_reg_off) begin
            transmit_irq_select_q <= pwdata[transmit_irq_select_bit];
            receive_irq_select_q <= pwdata[receive_irq_select_lsb +: 2];
         end
      end
   end

   // status control bits cleared by disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_enable_q <= 1'b0;
         send_break_q <= 1'b0;
      end else if (flush) begin
         transmit_enable_q <= 1'b0;
         send_break_q <= 1'b0;
      end else if (wr && pready && paddr == status_control_reg_off) begin
         transmit_enable_q <= pwdata[transmit_enable_bit];
         send_break_q <= pwdata[send_break_bit];
      end
   end

   // transmit fifo: four eleven-bit entries, nine data bits used
   assign txf_push = wr && pready && paddr == transmit_data_reg_off;
   uart_fifo u_txf (
      .pclk(pclk), .presetn(presetn), .flush(flush),
      .push(txf_push), .wdata({2'h0, pwdata[8:0]}), .pop(txf_pop),
      .head(txf_head), .count(txf_count), .full(txf_full)
   );

   // baud clock runs only while enabled, restarts cleared
   uart_baud u_baud (
      .pclk(pclk), .presetn(presetn), .run(module_enable), .divisor(baud_q), .tick(tick)
   );

   // transmitter: fifo to shift register, then shift on ticks
   assign txf_pop = (tx_state_q == tx_idle) && transmit_enable_q && (txf_count != 3'h0) && !flush;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_q <= tx_idle;
         tx_shift_q <= 12'hfff;
         tx_bits_q <= 4'h0;
         tx_sub_q <= 4'h0;
         tx_line_q <= 1'b1;
      end else if (flush) begin
         tx_state_q <= tx_idle;
         tx_line_q <= 1'b1;
         tx_sub_q <= 4'h0;
      end else begin
         case (tx_state_q)
            tx_idle: begin
               tx_line_q <= 1'b1;
               if (txf_pop) begin
                  // start bit first; parity or ninth bit above data; stops above
                  case (data_parity_select)
                     fmt_8e: tx_shift_q <= {2'h3, par8(txf_head[7:0]), txf_head[7:0], 1'b0};
                     fmt_8o: tx_shift_q <= {2'h3, ~par8(txf_head[7:0]), txf_head[7:0], 1'b0};
                     fmt_9n: tx_shift_q <= {2'h3, txf_head[8:0], 1'b0};
                     default: tx_shift_q <= {3'h7, txf_head[7:0], 1'b0};
                  endcase
                  tx_bits_q <= frame_len + 4'h2 + {3'h0, mode_q[stop_bit_select_bit]};
                  tx_sub_q <= 4'h0;
                  tx_state_q <= tx_shift;
               end
            end
            tx_shift: begin
               if (tick) begin
                  if (tx_sub_q == 4'h0) begin
                     if (tx_bits_q == 4'h0) begin
                        tx_state_q <= tx_idle;
                        tx_line_q <= 1'b1;
                     end else begin
                        tx_line_q <= tx_shift_q[0];
                        tx_shift_q <= {1'b1, tx_shift_q[11:1]};
                        tx_bits_q <= tx_bits_q - 4'h1;
                     end
                  end
                  tx_sub_q <= tx_sub_q + 4'h1;
               end
            end
            default: tx_state_q <= tx_idle;
         endcase
      end
   end

   // line output: break overrides everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_out_line <= 1'b1;
      end else begin
         serial_out_line <= send_break_q ? 1'b0 : tx_line_q;
      end
   end

   // transmit irq pulse; break never sets it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_irq_flag <= 1'b0;
      end else begin
         transmit_irq_flag <= txf_pop && !send_break_q
            && (!transmit_irq_select_q || (txf_count == 3'h1 && !txf_push));
      end
   end

   // receive input synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= serial_in_line;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   // receiver: falling edge start, mid-bit sampling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_q <= rx_idle;
         receive_shift_reg_q <= 10'h000;
         rx_bits_q <= 4'h0;
         rx_sub_q <= 4'h0;
      end else if (flush) begin
         rx_state_q <= rx_idle;
         rx_sub_q <= 4'h0;
      end else begin
         case (rx_state_q)
            rx_idle: begin
               if (rx_prev_q && !rx_sync_q) begin
                  rx_state_q <= rx_bits;
                  rx_sub_q <= 4'h0;
                  rx_bits_q <= 4'h0;
               end
            end
            rx_bits: begin
               if (tick) begin
                  rx_sub_q <= rx_sub_q + 4'h1;
                  if (rx_sub_q == mid_tick) begin
                     if (rx_bits_q == 4'h0 && rx_sync_q) begin
                        rx_state_q <= rx_idle; // false start
                     end else if (rx_bits_q == frame_len + 4'h1) begin
                        rx_state_q <= rx_idle;
                     end else begin
                        receive_shift_reg_q <= {rx_sync_q, receive_shift_reg_q[9:1]};
                     end
                     rx_bits_q <= rx_bits_q + 4'h1;
                  end
               end
            end
            default: rx_state_q <= rx_idle;
         endcase
      end
   end

   // stop-bit sample completes a character
   logic rx_done; // stop sampled this cycle
   logic [8:0] rx_data; // aligned received bits
   logic rx_parity_error_flag; // parity mismatch
   assign rx_done = (rx_state_q == rx_bits) && tick && (rx_sub_q == mid_tick) && (rx_bits_q == frame_len + 4'h1);
   assign rx_data = (frame_len == 4'h9) ? receive_shift_reg_q[9:1] : {1'b0, receive_shift_reg_q[9:2]};
   always_comb begin
      case (data_parity_select)
         fmt_8e: rx_parity_error_flag = par8(rx_data[7:0]) != receive_shift_reg_q[9];
         fmt_8o: rx_parity_error_flag = par8(rx_data[7:0]) == receive_shift_reg_q[9];
         default: rx_parity_error_flag = 1'b0;
      endcase
   end
   assign rxf_wdata = {!rx_sync_q, (data_parity_select == fmt_9n) ? 1'b0 : rx_parity_error_flag,
                       (data_parity_select == fmt_9n) ? rx_data : {1'b0, rx_data[7:0]}};
   assign rxf_push = rx_done && !rxf_full;
   assign rxf_pop = rd && pready && paddr == receive_data_reg_off;

   uart_fifo u_rxf (
      .pclk(pclk), .presetn(presetn), .flush(flush),
      .push(rxf_push), .wdata(rxf_wdata), .pop(rxf_pop),
      .head(rxf_head), .count(rxf_count), .full(rxf_full)
   );

   // overrun: full fifo meets stop bit; cleared only by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_flag_q <= 1'b0;
      end else if (flush) begin
         overrun_flag_q <= 1'b0;
      end else if (rx_done && rxf_full) begin
         overrun_flag_q <= 1'b1;
      end else if (wr && pready && paddr == status_control_reg_off && !pwdata[overrun_bit]) begin
         overrun_flag_q <= 1'b0;
      end
   end

   // receive irq pulse by selected level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_irq_flag <= 1'b0;
      end else begin
         case (receive_irq_select_q)
            2'h2: receive_irq_flag <= rxf_push && (rxf_count + {2'h0, 1'b1} - {2'h0, rxf_pop} == 3'h3);
            2'h3: receive_irq_flag <= rxf_push && (rxf_count + {2'h0, 1'b1} - {2'h0, rxf_pop} == 3'h4);
            default: receive_irq_flag <= rxf_push;
         endcase
      end
   end

   // read mux, registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            mode_reg_off: prdata <= {16'h0000, mode_q};
            baud_divisor_reg_off: prdata <= {16'h0000, baud_q};
            receive_data_reg_off: prdata <= {23'h000000, rxf_head[8:0]};
            status_control_reg_off: begin
               prdata <= 32'h00000000;
               prdata[transmit_irq_select_bit] <= transmit_irq_select_q;
               prdata[send_break_bit] <= send_break_q;
               prdata[transmit_enable_bit] <= transmit_enable_q;
               prdata[transmit_fifo_full_bit] <= txf_full;
               prdata[transmit_idle_bit] <= (tx_state_q == tx_idle) && (txf_count == 3'h0);
               prdata[receive_irq_select_lsb +: 2] <= receive_irq_select_q;
               prdata[receive_idle_bit] <= (rx_state_q == rx_idle);
               prdata[parity_error_bit] <= rxf_head[9] && (rxf_count != 3'h0);
               prdata[framing_error_bit] <= rxf_head[10] && (rxf_count != 3'h0);
               prdata[overrun_bit] <= overrun_flag_q;
               prdata[receive_data_available_bit] <= (rxf_count != 3'h0);
            end
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule : uart_core
`default_nettype wire

/* File: hdl/uart_pkg.sv */
// register map, field positions, reset values and format codes of the serial port
// assumes a 32-bit apb slave with word-aligned registers
`default_nettype none
package uart_pkg;
   localparam logic [11:0] mode_reg_off = 12'h000; // mode_reg
   localparam logic [11:0] status_control_reg_off = 12'h004; // status_control_reg
   localparam logic [11:0] transmit_data_reg_off = 12'h008; // transmit_data_reg
   localparam logic [11:0] receive_data_reg_off = 12'h00c; // receive_data_reg
   localparam logic [11:0] baud_divisor_reg_off = 12'h010; // baud_divisor_reg
   localparam logic [11:0] irq_flag_reg_off = 12'h014; // irq flags offset, not decoded by uart_core
   // mode_reg fields
   localparam int module_enable_bit = 15;
   localparam int data_parity_select_lsb = 1;
   localparam int stop_bit_select_bit = 0;
   // status_control_reg fields
   localparam int transmit_irq_select_bit = 15;
   localparam int send_break_bit = 11;
   localparam int transmit_enable_bit = 10;
   localparam int transmit_fifo_full_bit = 9;
   localparam int transmit_idle_bit = 8;
   localparam int receive_irq_select_lsb = 6;
   localparam int receive_idle_bit = 4;
   localparam int framing_error_bit = 2;
   localparam int overrun_bit = 1;
   localparam int receive_data_available_bit = 0;
   // reset values and the parity_error_bit position
   localparam logic [15:0] mode_reset = 16'h0000;
   localparam logic [15:0] baud_reset = 16'h0000;
   localparam int parity_error_bit = 3;
   // data_parity_select codes
   localparam logic [1:0] fmt_8n = 2'h0;
   localparam logic [1:0] fmt_8e = 2'h1;
   localparam logic [1:0] fmt_8o = 2'h2;
   localparam logic [1:0] fmt_9n = 2'h3;
   // fifo geometry and baud oversampling
   localparam int fifo_depth = 4;
   localparam int fifo_width = 11;
   localparam int baud_oversample = 16;
   localparam logic [3:0] mid_tick = 4'h7;
endpackage : uart_pkg
`default_nettype wire

/* File: hdl/uart_fifo.sv */
// four-entry fifo with registered head output
// assumes push and pop are single-cycle strobes on pclk
`default_nettype none
module uart_fifo
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   input wire logic push,
   input wire logic [fifo_width-1:0] wdata,
   input wire logic pop,
   output logic [fifo_width-1:0] head,
   output logic [2:0] count,
   output logic full
);
   logic [fifo_width-1:0] mem_q [fifo_depth]; // storage
   logic [1:0] wp_q; // write pointer
   logic [1:0] rp_q; // read pointer
   logic [2:0] cnt_q; // occupancy
   logic do_push; // accepted write
   logic do_pop; // accepted read
   logic [1:0] rp_next; // pointer after read
   // full writes are dropped, empty reads ignored
   assign do_push = push && (cnt_q != 3'(fifo_depth)) && !flush;
   assign do_pop = pop && (cnt_q != 3'h0) && !flush;
   assign rp_next = do_pop ? rp_q + 2'h1 : rp_q;
   // pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q <= 2'h0;
         rp_q <= 2'h0;
         cnt_q <= 3'h0;
      end else if (flush) begin
         wp_q <= 2'h0;
         rp_q <= 2'h0;
         cnt_q <= 3'h0;
      end else begin
         if (do_push) wp_q <= wp_q + 2'h1;
         rp_q <= rp_next;
         cnt_q <= cnt_q + 3'(do_push) - 3'(do_pop);
      end
   end
   // storage write
   always_ff @(posedge pclk) begin
      if (do_push) mem_q[wp_q] <= wdata;
   end
   // registered head; stale value held when empty
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head <= '0;
      end else if (do_push && ((cnt_q == 3'h0) || (do_pop && cnt_q == 3'h1))) begin
         head <= wdata;
      end else if (do_pop && cnt_q > 3'h1) begin
         head <= mem_q[rp_next];
      end
   end
   assign count = cnt_q;
   assign full = (cnt_q == 3'(fifo_depth));
endmodule : uart_fifo
`default_nettype wire

/* File: hdl/uart_baud.sv */
// baud tick generator: one pulse per oversample slot
// assumes divisor from a register on pclk
`default_nettype none
module uart_baud
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [15:0] divisor,
   output logic tick
);
   logic [15:0] cnt_q; // down counter
   // counter cleared while stopped so restart is immediate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_q == 16'h0000) begin
         cnt_q <= divisor;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q - 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule : uart_baud
`default_nettype wire

/* File: bench/uart_core_sva.sv */
// checker for the serial port: apb handshake, break, idle line, irq pulses
// assumes binding to uart_core; shadows enable and break from apb writes
`default_nettype none
module uart_core_sva
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_in_line,
   input wire logic serial_out_line,
   input wire logic transmit_irq_flag,
   input wire logic receive_irq_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr; // write completes at this edge
   logic rd_setup; // read setup cycle
   logic en_q; // module enable as written
   logic brk_q; // break bit as written
   assign wr = psel && penable && pready && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   // shadow of enable and break; disable drops break
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         brk_q <= 1'b0;
      end else if (wr && paddr == mode_reg_off) begin
         en_q <= pwdata[module_enable_bit];
         brk_q <= brk_q && pwdata[module_enable_bit];
      end else if (wr && paddr == status_control_reg_off) begin
         brk_q <= pwdata[send_break_bit] && en_q;
      end
   end
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
   a_no_slave_err: assert property (!pslverr) else $error("slave error seen");
   a_prdata_holds: assert property ($changed(prdata) |-> $past(rd_setup)) else $error("read data moved");
   a_break_low: assert property (brk_q [*3] |-> !serial_out_line) else $error("line high in break");
   a_break_no_irq: assert property (brk_q [*2] |-> !transmit_irq_flag) else $error("irq in break");
   a_tx_irq_pulse: assert property (transmit_irq_flag |=> !transmit_irq_flag) else $error("tx irq long");
   a_rx_irq_pulse: assert property ($rose(receive_irq_flag) |=> $fell(receive_irq_flag)) else $error("rx irq long");
   a_tx_irq_enabled: assert property (transmit_irq_flag |-> en_q) else $error("tx irq while off");
   a_off_line_high: assert property (!en_q [*4] |-> serial_out_line) else $error("line low while off");
   a_start_bit_len: assert property ($fell(serial_out_line) && !brk_q |-> !serial_out_line [*8])
      else $error("short start bit");
   cover property (transmit_irq_flag);
   cover property (receive_irq_flag);
   cover property (brk_q [*3]);
   cover property (pready && !pwrite);
endmodule : uart_core_sva
bind uart_core uart_core_sva uart_core_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .serial_in_line, .serial_out_line, .transmit_irq_flag, .receive_irq_flag);
`default_nettype wire

/* File: bench/remote_node.sv */
// remote serial node: sends frames into the core, decodes frames it sends
// assumes divisor 0, so one bit lasts sixteen pclk cycles
`default_nettype none
module remote_node
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic serial_out_line,
   input wire logic [1:0] fmt,
   input wire logic two_stop,
   output logic serial_in_line
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int bit_cycles = 16; // one bit at divisor 0
   logic [9:0] q[$]; // decoded frames, bit 9 marks a low stop
   initial serial_in_line = 1'b1; // idle high, pulled up
   // one frame, lsb first, with optional bad parity or low stop
   task automatic send(input logic [8:0] x, input logic bad_par, input logic bad_stop);
      logic [11:0] f;
      logic p;
      p = (fmt == fmt_9n) ? x[8] : (^x[7:0]) ^ (fmt == fmt_8o) ^ bad_par;
      f = (fmt == fmt_8n) ? {2'b11, !bad_stop, x[7:0], 1'b0} : {1'b1, !bad_stop, p, x[7:0], 1'b0};
      for (int i = 0; i < 12; i++) begin
         @(posedge pclk);
         serial_in_line <= f[i];
         repeat (bit_cycles - 1) @(posedge pclk);
      end
   endtask : send
   // decoder: mid-bit samples after each falling edge
   initial begin
      logic [9:0] w;
      forever begin
         @(negedge serial_out_line);
         repeat (bit_cycles / 2) @(posedge pclk);
         w = '0;
         for (int i = 0; i < 9; i++) begin
            repeat (bit_cycles) @(posedge pclk);
            w[i] = serial_out_line;
         end
         if (fmt == fmt_8n) begin
            w[9] = !w[8];
            w[8] = 1'b0;
         end else begin
            repeat (bit_cycles) @(posedge pclk);
            w[9] = !serial_out_line;
         end
         if (two_stop) begin
            repeat (bit_cycles) @(posedge pclk);
            w[9] = w[9] | !serial_out_line;
         end
         q.push_back(w);
      end
   end
endmodule : remote_node
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for uart_core over apb with the remote node
// assumes divisor 0 (reset value), one bit is sixteen pclk cycles
`default_nettype none
module tb
   import uart_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, serial_in_line, serial_out_line, transmit_irq_flag, receive_irq_flag;
   logic [1:0] fmt = fmt_8n;
   logic two_stop = 1'b0;
   logic [8:0] d[6]; // characters of one test
   int bad_count = 0, num_checks = 0, cyc = 0, tx_irqs = 0, rx_irqs = 0, seed = 85025, t, t0;
   localparam logic [31:0] idle_st = (32'h1 << transmit_idle_bit) | (32'h1 << receive_idle_bit);
   always #20 pclk = ~pclk;
   uart_core uart_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .serial_in_line, .serial_out_line, .transmit_irq_flag, .receive_irq_flag);
   remote_node remote_node_i (.pclk, .serial_out_line, .fmt, .two_stop, .serial_in_line);
   // count irq pulses and cycles; cut a hang short
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      tx_irqs <= tx_irqs + (transmit_irq_flag === 1'b1);
      rx_irqs <= rx_irqs + (receive_irq_flag === 1'b1);
      if (cyc == 60000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; read data lands in r
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      bad_count += (n >= 50);
   endtask : apb
   // expected decoded frame for a format
   function automatic logic [31:0] frame(input logic [1:0] f, input logic [8:0] x);
      case (f)
         fmt_9n: return {23'h0, x};
         fmt_8e: return {23'h0, ^x[7:0], x[7:0]};
         fmt_8o: return {23'h0, ~^x[7:0], x[7:0]};
         default: return {24'h0, x[7:0]};
      endcase
   endfunction : frame
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, status_control_reg_off, 0);
      chk(r, idle_st);
      apb(0, 12'h018, 0);
      chk(r, 0);
      // transmit: every format, tx irq mode, full fifo
      for (int f = 0; f < 4; f++) begin
         fmt <= f[1:0];
         two_stop <= f[0];
         apb(1, mode_reg_off, {16'h0, 1'b1, 12'h0, f[1:0], f[0]});
         chk(serial_out_line, 1);
         remote_node_i.q.delete();
         t0 = tx_irqs;
         for (int i = 0; i < 6; i++) begin
            d[i] = 9'($random(seed)) & (f == 3 ? 9'h1ff : 9'h0ff);
         end
         apb(1, transmit_data_reg_off, {23'h0, d[0]});
         apb(1, status_control_reg_off, (32'h1 << 10) | (f[1] << 15));
         for (t = 0; t < 4 && serial_out_line !== 1'b0; t++) @(posedge pclk);
         chk(serial_out_line, 0);
         for (int i = 1; i < 6; i++) apb(1, transmit_data_reg_off, {23'h0, d[i]});
         apb(0, status_control_reg_off, 0);
         chk(r[transmit_fifo_full_bit], 1);
         for (t = 0; t < 1500 && remote_node_i.q.size() < 5; t++) @(posedge pclk);
         repeat (300) @(posedge pclk);
         chk(remote_node_i.q.size(), 5);
         for (int i = 0; i < 5; i++) chk(remote_node_i.q[i], frame(f[1:0], d[i]));
         chk(tx_irqs - t0, f[1] ? 2 : 5);
         $display("tx format %0d done", f);
      end
      // break while idle
      apb(1, status_control_reg_off, 32'hc00);
      repeat (220) @(posedge pclk);
      chk(serial_out_line, 0);
      apb(1, status_control_reg_off, 32'h400);
      repeat (300) @(posedge pclk);
      chk(serial_out_line, 1);
      chk(tx_irqs - t0, 2);
      $display("break done");
      // receive: irq codes, errors, overrun, empty read
      fmt <= fmt_8e;
      two_stop <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         apb(1, mode_reg_off, 32'h3);
         apb(1, mode_reg_off, 32'h8003);
         apb(1, status_control_reg_off, c << 6);
         t0 = rx_irqs;
         for (int i = 0; i < 5; i++) begin
            d[i] = 9'($random(seed)) & 9'h0ff;
            if (i < 4 || c == 3) remote_node_i.send(d[i], c == 0 && i == 0, c == 0 && i == 1);
         end
         chk(rx_irqs - t0, c < 2 ? 4 : 1);
         apb(0, status_control_reg_off, 0);
         chk(r[1:0], c == 3 ? 2'b11 : 2'b01);
         for (int i = 0; i < 4; i++) begin
            apb(0, status_control_reg_off, 0);
            if (c == 0) chk(r[3:2], i == 0 ? 2'b10 : i == 1 ? 2'b01 : 2'b00);
            apb(0, receive_data_reg_off, 0);
            chk(r[7:0], d[i][7:0]);
         end
         apb(0, status_control_reg_off, 0);
         chk(r[1:0], c == 3 ? 2'b10 : 2'b00);
         apb(0, receive_data_reg_off, 0);
         chk(r[7:0], d[3][7:0]);
         remote_node_i.send(d[4], 0, 0);
         apb(0, receive_data_reg_off, 0);
         chk(r[7:0], d[4][7:0]);
         $display("rx code %0d done", c);
      end
      apb(1, status_control_reg_off, 32'h0);
      apb(0, status_control_reg_off, 0);
      chk(r[overrun_bit], 0);
      apb(1, mode_reg_off, 32'h3);
      apb(0, status_control_reg_off, 0);
      chk(r, idle_st);
      apb(0, mode_reg_off, 0);
      chk(r, 32'h3);
      // device reset empties the receive fifo
      apb(1, mode_reg_off, 32'h8003);
      remote_node_i.send(9'h05a, 0, 0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1, mode_reg_off, 32'h8003);
      apb(0, status_control_reg_off, 0);
      chk(r[receive_data_available_bit], 0);
      $display("reset done");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
